/* File: arr_top.sv */
// arr_top: three adc result registers behind an apb slave, with interrupts
// assumes: sequencer store strobes and data are synchronous to mclk_i
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module arr_top
  import arr_pkg::*;
#(
  parameter int unsigned NUM_RES = ARR_NUM_RES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // converter sequencer side
  input wire logic [2:0] store_i,
  input wire logic [9:0] store_data_i,
  // interrupt
  output logic irq_o
);

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  function automatic arr_sel_e sel_of(input logic [11:0] addr);
    arr_sel_e s;
    case (addr)
      ARR_OFS_RESULT_ONE: s = ARR_SEL_RES0;
      ARR_OFS_RESULT_TWO: s = ARR_SEL_RES1;
      ARR_OFS_RESULT_THREE: s = ARR_SEL_RES2;
      ARR_OFS_IRQ_STATUS: s = ARR_SEL_STATUS;
      ARR_OFS_IRQ_MASK: s = ARR_SEL_MASK;
      default: s = ARR_SEL_NONE;
    endcase
    return s;
  endfunction

  // packs one holder into its register word; unused bits stay zero
  function automatic logic [31:0] word_of(input arr_slot_s s);
    logic [31:0] w;
    w = ARR_RST_RESULT;
    w[ARR_RES_MSB:ARR_RES_LSB] = s.value;
    w[ARR_OVR_BIT] = s.overrun;
    w[ARR_STORED_BIT] = s.stored;
    return w;
  endfunction

  // ------------------------------------------------------------------
  // state and holders
  // ------------------------------------------------------------------
  arr_top_s q, d;
  arr_slot_s slot [NUM_RES];
  logic [NUM_RES-1:0] rd_clr;
  logic [NUM_RES-1:0] store_evt;
  logic [NUM_RES-1:0] ovr_evt;
  arr_sel_e sel;
  logic rd_edge;
  logic wr_edge;
  logic [2*NUM_RES-1:0] evt_vec;

  assign sel = sel_of(paddr_i);
  // read clears and read capture happen on the first access edge (writes land on the second, with pready),
  // so the word returned is exactly the word that the clear acts on
  assign rd_edge = psel_i && penable_i && !q.ack && !pwrite_i;
  assign wr_edge = psel_i && penable_i && q.ack && pwrite_i;
  // stored events in the low half, overrun events in the high half
  assign evt_vec = {ovr_evt, store_evt};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RES; gi++) begin : g_slot
      assign rd_clr[gi] = rd_edge && (sel == arr_sel_e'(gi));
      arr_slot u_slot (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .store_i(store_i[gi]),
        .data_i(store_data_i),
        .rd_clr_i(rd_clr[gi]),
        .slot_o(slot[gi]),
        .store_evt_o(store_evt[gi]),
        .ovr_evt_o(ovr_evt[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // bus and interrupt next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = psel_i && penable_i && !q.ack;
    if (rd_edge || (psel_i && penable_i && !q.ack)) begin
      d.slverr = (sel == ARR_SEL_NONE);
      d.rdata = '0;
    end
    if (rd_edge) begin
      case (sel)
        ARR_SEL_RES0: d.rdata = word_of(slot[0]);
        ARR_SEL_RES1: d.rdata = word_of(slot[1]);
        ARR_SEL_RES2: d.rdata = word_of(slot[2]);
        ARR_SEL_STATUS: d.rdata = {26'h0, q.irq_status};
        ARR_SEL_MASK: d.rdata = {26'h0, q.irq_mask};
        default: d.rdata = '0;
      endcase
    end
    // result and status words ignore writes
    if (wr_edge && (sel == ARR_SEL_MASK)) begin
      d.irq_mask = pwdata_i[5:0];
    end
    // a status read clears, but a same-cycle event still lands
    if (rd_edge && (sel == ARR_SEL_STATUS)) begin
      d.irq_status = '0;
    end
    d.irq_status = d.irq_status | evt_vec;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata_o = q.rdata;
  assign pready_o = q.ack;
  assign pslverr_o = q.ack && q.slverr;
  assign irq_o = |(q.irq_status & q.irq_mask);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_res_zero_bits;
    @(posedge mclk_i) disable iff (rst_i)
    (rd_edge && (sel inside {ARR_SEL_RES0, ARR_SEL_RES1, ARR_SEL_RES2}))
      |=> (prdata_o[31:16] == 16'h0000) && (prdata_o[5:2] == 4'h0);
  endproperty
  a_res_zero_bits: assert property (p_res_zero_bits)
    else $error("reserved result bits not zero");

  property p_res_write_ignored;
    @(posedge mclk_i) disable iff (rst_i)
    (wr_edge && (sel == ARR_SEL_RES0) && !store_i[0])
      |=> $stable(slot[0].value);
  endproperty
  a_res_write_ignored: assert property (p_res_write_ignored)
    else $error("write changed a result");

  property p_read_returns_old;
    @(posedge mclk_i) disable iff (rst_i)
    (rd_edge && (sel == ARR_SEL_RES1))
      |=> (prdata_o[ARR_RES_MSB:ARR_RES_LSB] == $past(slot[1].value))
        && (prdata_o[ARR_OVR_BIT] == $past(slot[1].overrun))
        && pready_o;
  endproperty
  a_read_returns_old: assert property (p_read_returns_old)
    else $error("read word not the pre-clear value");

  property p_one_wait;
    @(posedge mclk_i) disable iff (rst_i)
    (psel_i && !penable_i) ##1 (psel_i && penable_i)
      |-> !pready_o ##1 pready_o;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("pready timing wrong");

  // a mask write in the same edge may legally switch the source off
  property p_irq_store;
    @(posedge mclk_i) disable iff (rst_i)
    (store_i[2] && q.irq_mask[ARR_IRQ_STORED_LSB + 2]
      && !(wr_edge && (sel == ARR_SEL_MASK))) |=> irq_o;
  endproperty
  a_irq_store: assert property (p_irq_store)
    else $error("store event did not raise irq");

  // ------------------------------------------------------------------
  // bus answer checks
  // ------------------------------------------------------------------
  // pready is a one-cycle answer; a longer one would end the next
  // transfer before its own access phase
  property p_ready_pulse;
    @(posedge mclk_i) disable iff (rst_i)
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");

  property p_ready_needs_sel;
    @(posedge mclk_i) disable iff (rst_i)
    !(psel_i && penable_i) |=> !pready_o;
  endproperty
  a_ready_needs_sel: assert property (p_ready_needs_sel)
    else $error("pready without an access phase");

  property p_err_unmapped;
    @(posedge mclk_i) disable iff (rst_i)
    (psel_i && penable_i && !pready_o && (sel == ARR_SEL_NONE))
      |=> pslverr_o && (prdata_o == 32'h0000_0000);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access not refused");

  // writes to the read-only words are dropped quietly, with no error
  property p_err_mapped;
    @(posedge mclk_i) disable iff (rst_i)
    (psel_i && penable_i && !pready_o && (sel != ARR_SEL_NONE))
      |=> pready_o && !pslverr_o;
  endproperty
  a_err_mapped: assert property (p_err_mapped)
    else $error("mapped access answered with an error");

  // software may take prdata late, so it holds between transfers
  property p_rdata_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !(psel_i && penable_i && !pready_o) |=> $stable(prdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside a capture");

  // ------------------------------------------------------------------
  // holder checks
  // ------------------------------------------------------------------
  // every holder returns the word as it stood before its clear
  for (gi = 0; gi < NUM_RES; gi++) begin : g_chk
    property p_read_word;
      @(posedge mclk_i) disable iff (rst_i)
      rd_clr[gi]
        |=> (prdata_o[ARR_RES_MSB:ARR_RES_LSB] == $past(slot[gi].value))
          && (prdata_o[ARR_OVR_BIT] == $past(slot[gi].overrun))
          && (prdata_o[ARR_STORED_BIT] == $past(slot[gi].stored));
    endproperty
    a_read_word: assert property (p_read_word)
      else $error("result word not returned before the clear");

    property p_write_dropped;
      @(posedge mclk_i) disable iff (rst_i)
      (wr_edge && (sel == arr_sel_e'(gi)) && !store_i[gi])
        |=> $stable(slot[gi]);
    endproperty
    a_write_dropped: assert property (p_write_dropped)
      else $error("write changed a result holder");
  end

  // ------------------------------------------------------------------
  // interrupt checks
  // ------------------------------------------------------------------
  property p_status_sets;
    @(posedge mclk_i) disable iff (rst_i)
    (|evt_vec) |=> ((q.irq_status & $past(evt_vec)) == $past(evt_vec));
  endproperty
  a_status_sets: assert property (p_status_sets)
    else $error("event did not set its status bit");

  property p_status_clear;
    @(posedge mclk_i) disable iff (rst_i)
    (rd_edge && (sel == ARR_SEL_STATUS) && !(|evt_vec))
      |=> (q.irq_status == ARR_RST_IRQ);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status read did not clear");

  property p_status_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !(rd_edge && (sel == ARR_SEL_STATUS)) && !(|evt_vec)
      |=> $stable(q.irq_status);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status changed without event or read");

  property p_mask_write;
    @(posedge mclk_i) disable iff (rst_i)
    (wr_edge && (sel == ARR_SEL_MASK))
      |=> (q.irq_mask == $past(pwdata_i[5:0]));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not taken");

  property p_mask_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !(wr_edge && (sel == ARR_SEL_MASK)) |=> $stable(q.irq_mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without a write");

  c_res_read: cover property (@(posedge mclk_i) disable iff (rst_i)
    rd_clr[0] && slot[0].overrun);
  c_irq: cover property (@(posedge mclk_i) disable iff (rst_i)
    $rose(irq_o));
  c_unmapped: cover property (@(posedge mclk_i) disable iff (rst_i)
    pslverr_o);

endmodule // arr_top
`default_nettype wire

/* File: arr_pkg.sv */
// arr_pkg: shared constants and carrier types of the adc result registers
// assumes: 32-bit register bus, one aligned word per register
package arr_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int unsigned ARR_NUM_RES = 3;
  localparam int unsigned ARR_RES_W = 10;
  localparam int unsigned ARR_DATA_W = 32;
  localparam int unsigned ARR_ADDR_W = 12;
  localparam int unsigned ARR_IRQ_W = 2 * ARR_NUM_RES;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] ARR_OFS_RESULT_ONE = 12'h000;
  localparam logic [11:0] ARR_OFS_RESULT_TWO = 12'h004;
  localparam logic [11:0] ARR_OFS_RESULT_THREE = 12'h008;
  localparam logic [11:0] ARR_OFS_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] ARR_OFS_IRQ_MASK = 12'h010;

  // ------------------------------------------------------------------
  // field positions of a result register
  // ------------------------------------------------------------------
  localparam int unsigned ARR_RES_LSB = 6;
  localparam int unsigned ARR_RES_MSB = 15;
  localparam int unsigned ARR_OVR_BIT = 1;
  localparam int unsigned ARR_STORED_BIT = 0;

  // irq layout: stored events in low half, overrun events in high half
  localparam int unsigned ARR_IRQ_STORED_LSB = 0;
  localparam int unsigned ARR_IRQ_OVR_LSB = ARR_NUM_RES;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] ARR_RST_RESULT = 32'h0000_0000;
  localparam logic [5:0] ARR_RST_IRQ = 6'h00;

  // ------------------------------------------------------------------
  // carriers and state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ARR_SEL_RES0,
    ARR_SEL_RES1,
    ARR_SEL_RES2,
    ARR_SEL_STATUS,
    ARR_SEL_MASK,
    ARR_SEL_NONE
  } arr_sel_e;

  typedef struct packed {
    logic [9:0] value;
    logic overrun;
    logic stored;
  } arr_slot_s;

  typedef struct packed {
    logic ack;
    logic slverr;
    logic [31:0] rdata;
    logic [5:0] irq_status;
    logic [5:0] irq_mask;
  } arr_top_s;

endpackage

/* File: arr_slot.sv */
// arr_slot: one conversion result holder with stored and overrun flags
// assumes: store and read-clear strobes are one-cycle pulses on mclk_i
`timescale 1ns/1ps
`default_nettype none
module arr_slot
  import arr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic store_i,
  input wire logic [9:0] data_i,
  input wire logic rd_clr_i,
  output arr_slot_s slot_o,
  output logic store_evt_o,
  output logic ovr_evt_o
);

  arr_slot_s q, d;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    // a read in the same cycle takes the old value, so no overrun then
    ovr_evt_o = store_i && q.stored && !rd_clr_i;
    store_evt_o = store_i;
    if (rd_clr_i) begin
      d.stored = 1'b0;
      d.overrun = 1'b0;
    end
    if (store_i) begin
      d.value = data_i;
      d.stored = 1'b1;
    end
    if (ovr_evt_o) begin
      d.overrun = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign slot_o = q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_value_upd;
    @(posedge mclk_i) disable iff (rst_i)
    store_i |=> (q.value == $past(data_i));
  endproperty
  a_value_upd: assert property (p_value_upd)
    else $error("result not taken on store");

  property p_value_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !store_i |=> $stable(q.value);
  endproperty
  a_value_hold: assert property (p_value_hold)
    else $error("result changed without store");

  property p_ovr_set;
    @(posedge mclk_i) disable iff (rst_i)
    (store_i && q.stored && !rd_clr_i) |=> q.overrun;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun not flagged");

  property p_ovr_cause;
    @(posedge mclk_i) disable iff (rst_i)
    $rose(q.overrun) |-> $past(q.stored) && $past(store_i);
  endproperty
  a_ovr_cause: assert property (p_ovr_cause)
    else $error("overrun set without a lost result");

  property p_ovr_clr;
    @(posedge mclk_i) disable iff (rst_i)
    (rd_clr_i && !store_i) |=> !q.overrun && !q.stored;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr)
    else $error("read did not clear flags");

  property p_stored_set;
    @(posedge mclk_i) disable iff (rst_i)
    store_i |=> q.stored;
  endproperty
  a_stored_set: assert property (p_stored_set)
    else $error("stored flag not set");

  property p_stored_cause;
    @(posedge mclk_i) disable iff (rst_i)
    $rose(q.stored) |-> $past(store_i);
  endproperty
  a_stored_cause: assert property (p_stored_cause)
    else $error("stored flag set without store");

  c_overrun: cover property (@(posedge mclk_i) disable iff (rst_i)
    $rose(q.overrun));

endmodule // arr_slot
`default_nettype wire

/* File: arr_top_bench.sv */
// arr_top_bench: self-checking bench for the adc result registers
// assumes: arr_pkg and arr_top compiled first; single 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module arr_top_bench;
  import arr_pkg::*;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] store = 3'h0;
  logic [9:0] store_data = 10'h000;
  logic irq;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic err;
  logic [11:0] ofs [3];
  logic [9:0] val [3];

  always #5 mclk_i = ~mclk_i;

  arr_top #(.NUM_RES(ARR_NUM_RES)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .store_i(store), .store_data_i(store_data), .irq_o(irq)
  );

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp=%h got=%h", nm, e, g);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    // no cycle budget here: only the watchdog ends a missing answer
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
    chk({nm, "_err"}, 32'h0000_0000, {31'h0, err});
  endtask

  // sequencer store strobe, one cycle wide
  task automatic put(input logic [2:0] m, input logic [9:0] d);
    @(posedge mclk_i);
    store <= m;
    store_data <= d;
    @(posedge mclk_i);
    store <= 3'h0;
  endtask

  function automatic logic [31:0] word(input logic [9:0] v,
                                       input logic o, input logic s);
    word = {16'h0000, v, 4'h0, o, s};
  endfunction

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    ofs[0] = ARR_OFS_RESULT_ONE;
    ofs[1] = ARR_OFS_RESULT_TWO;
    ofs[2] = ARR_OFS_RESULT_THREE;
    val[0] = 10'h3ff;
    val[1] = 10'h201;
    val[2] = 10'h155;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd_chk("reset_res", ofs[i], ARR_RST_RESULT);
    end
    rd_chk("reset_mask", ARR_OFS_IRQ_MASK, 32'h0000_0000);
    chk("reset_irq", 32'h0, {31'h0, irq});
    // fresh result per register, then stored flag gone after read
    for (int i = 0; i < 3; i++) begin
      put(3'(1 << i), val[i]);
      rd_chk("res_first", ofs[i], word(val[i], 1'b0, 1'b1));
      rd_chk("res_again", ofs[i], word(val[i], 1'b0, 1'b0));
    end
    // unread result overwritten: overrun shows once, then clears
    put(3'h2, 10'h0aa);
    put(3'h2, 10'h3c3);
    rd_chk("ovr_set", ofs[1], word(10'h3c3, 1'b1, 1'b1));
    rd_chk("ovr_clr", ofs[1], word(10'h3c3, 1'b0, 1'b0));
    rd_chk("ovr_none", ofs[0], word(val[0], 1'b0, 1'b0));
    // result registers ignore writes; stored flag stays clear
    apb(1'b1, ofs[0], 32'hffff_ffff);
    chk("wr_err", 32'h0, {31'h0, err});
    rd_chk("wr_ignored", ofs[0], word(val[0], 1'b0, 1'b0));
    rd_chk("res6", ofs[2], word(val[2], 1'b0, 1'b0));
    // unmapped address answers with an error and zero data
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    // interrupt: masked event, then unmasked overrun on register three
    apb(1'b0, ARR_OFS_IRQ_STATUS, 32'h0);
    apb(1'b1, ARR_OFS_IRQ_MASK, 32'hffff_ffff);
    rd_chk("mask_rw", ARR_OFS_IRQ_MASK, 32'h0000_003f);
    apb(1'b1, ARR_OFS_IRQ_MASK, 32'h0000_0000);
    put(3'h4, 10'h011);
    repeat (3) @(posedge mclk_i);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd_chk("status_st", ARR_OFS_IRQ_STATUS, 32'h0000_0004);
    apb(1'b1, ARR_OFS_IRQ_MASK, 32'h0000_0020);
    put(3'h4, 10'h022);
    repeat (3) @(posedge mclk_i);
    chk("irq_on", 32'h1, {31'h0, irq});
    rd_chk("status_ovr", ARR_OFS_IRQ_STATUS, 32'h0000_0024);
    repeat (3) @(posedge mclk_i);
    chk("irq_off", 32'h0, {31'h0, irq});
    rd_chk("res3_ovr", ofs[2], word(10'h022, 1'b1, 1'b1));
    // unmasked stored event; the status word ignores writes
    apb(1'b1, ARR_OFS_IRQ_MASK, 32'h0000_0007);
    apb(1'b1, ARR_OFS_IRQ_STATUS, 32'h0000_003f);
    rd_chk("status_wr", ARR_OFS_IRQ_STATUS, 32'h0000_0000);
    put(3'h4, 10'h133);
    repeat (3) @(posedge mclk_i);
    chk("irq_stored", 32'h1, {31'h0, irq});
    rd_chk("status_st3", ARR_OFS_IRQ_STATUS, 32'h0000_0004);
    // reset in mid-run brings every word back to zero
    put(3'h1, 10'h2c4);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk("rst_irq", 32'h0, {31'h0, irq});
    for (int i = 0; i < 3; i++) begin
      rd_chk("rst_res", ofs[i], ARR_RST_RESULT);
    end
    rd_chk("rst_mask", ARR_OFS_IRQ_MASK, 32'h0000_0000);
    rd_chk("rst_status", ARR_OFS_IRQ_STATUS, 32'h0000_0000);
    test_done();
  end

  // ------------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    test_done();
  end

endmodule // arr_top_bench
`default_nettype wire
